// ==== logic/acc_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module acc_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  accumulator,
	output logic             arith_overflow_bit,
	output logic             half_carry_flag,
	output logic             result_null_flag,
	output logic             skip_active,
	output logic             exec_done
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic              setup;
	logic              fire;
	logic              aligned;
	logic              hit_cmd;
	logic              hit_acc;
	logic              hit_status;
	logic              hit_file;
	logic              mapped;
	logic [6:0]        bus_index;

	assign setup      = psel & ~penable;
	assign fire       = psel & penable & pready;
	assign aligned    = (paddr[1:0] == 2'b00);
	assign hit_cmd    = (paddr == alu_pkg::CMD_OFFSET);
	assign hit_acc    = (paddr == alu_pkg::ACC_OFFSET);
	assign hit_status = (paddr == alu_pkg::STATUS_OFFSET);
	assign hit_file   = (paddr[11:9] == alu_pkg::FILE_PAGE) & aligned;
	assign mapped     = hit_cmd | hit_acc | hit_status | hit_file;
	assign bus_index  = paddr[8:2];

	////////////////////////////////////////////////////////////////////////
	// Instruction word taken from the command write data

	alu_pkg::instr_t   instr;
	alu_pkg::alu_out_t alu_res;
	alu_pkg::exec_state_t state;
	logic [7:0]        file_val;
	logic [7:0]        bus_file_val;
	logic              bad_op;

	always_comb begin
		instr.op     = alu_pkg::op_t'(pwdata[alu_pkg::OP_LSB +: 4]);
		instr.dest   = pwdata[alu_pkg::DEST_POS];
		instr.bitpos = pwdata[alu_pkg::BIT_LSB +: 3];
		instr.faddr  = pwdata[alu_pkg::FADDR_LSB +: 7];
		instr.imm    = pwdata[alu_pkg::IMM_LSB +: 8];
	end

	logic cmd_commit;
	logic exec_live;

	// A command write during a pending skip is discarded; it only ends the skip and pulses exec_done
	assign cmd_commit = fire & pwrite & hit_cmd;
	assign exec_live  = cmd_commit & (state == alu_pkg::EXEC_RUN);

	////////////////////////////////////////////////////////////////////////
	// Operand store and operation unit

	logic       ram_wr_en;
	logic [6:0] ram_wr_addr;
	logic [7:0] ram_wr_data;

	always_comb begin
		ram_wr_en   = 1'b0;
		ram_wr_addr = instr.faddr;
		ram_wr_data = alu_res.result;
		if (exec_live && alu_res.wr_file) begin
			ram_wr_en = 1'b1;
		end else if (fire && pwrite && hit_file) begin
			ram_wr_en   = 1'b1;
			ram_wr_addr = bus_index;
			ram_wr_data = pwdata[7:0];
		end
	end

	file_ram u_file_ram (
		.pclk      (pclk),
		.wr_en     (ram_wr_en),
		.wr_addr   (ram_wr_addr),
		.wr_data   (ram_wr_data),
		.exec_addr (instr.faddr),
		.exec_data (file_val),
		.bus_addr  (bus_index),
		.bus_data  (bus_file_val)
	);

	op_unit u_op_unit (
		.acc      (accumulator),
		.file_val (file_val),
		.instr    (instr),
		.out      (alu_res)
	);

	////////////////////////////////////////////////////////////////////////
	// Skip sequencing

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= alu_pkg::EXEC_RUN;
		end else if (cmd_commit) begin
			unique case (state)
				alu_pkg::EXEC_RUN: begin
					if (alu_res.skip) begin
						state <= alu_pkg::EXEC_SKIP;
					end
				end
				alu_pkg::EXEC_SKIP: begin
					state <= alu_pkg::EXEC_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_active <= alu_pkg::FLAG_RESET;
		end else if (cmd_commit) begin
			skip_active <= (state == alu_pkg::EXEC_RUN) & alu_res.skip;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_done <= 1'b0;
		end else begin
			exec_done <= cmd_commit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator <= alu_pkg::ACC_RESET;
		end else if (exec_live && alu_res.wr_acc) begin
			accumulator <= alu_res.result;
		end else if (fire && pwrite && hit_acc) begin
			accumulator <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags; software may preload them through the status word

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arith_overflow_bit <= alu_pkg::FLAG_RESET;
		end else if (exec_live && alu_res.upd_c) begin
			arith_overflow_bit <= alu_res.carry;
		end else if (fire && pwrite && hit_status) begin
			arith_overflow_bit <= pwdata[alu_pkg::STAT_C];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_carry_flag <= alu_pkg::FLAG_RESET;
		end else if (exec_live && alu_res.upd_dc) begin
			half_carry_flag <= alu_res.half;
		end else if (fire && pwrite && hit_status) begin
			half_carry_flag <= pwdata[alu_pkg::STAT_DC];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_null_flag <= alu_pkg::FLAG_RESET;
		end else if (exec_live && alu_res.upd_z) begin
			result_null_flag <= alu_res.zero;
		end else if (fire && pwrite && hit_status) begin
			result_null_flag <= pwdata[alu_pkg::STAT_Z];
		end
	end

	// Sticky mark for undefined opcodes; write one to clear.
	// Set and clear come from different transfers, so they never collide.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_op <= alu_pkg::FLAG_RESET;
		end else if (exec_live && alu_res.bad) begin
			bad_op <= 1'b1;
		end else if (fire && pwrite && hit_status && pwdata[alu_pkg::STAT_BAD]) begin
			bad_op <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer: sampled in setup so pready and prdata leave flops

	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_acc) begin
			next_prdata[7:0] = accumulator;
		end else if (hit_status) begin
			next_prdata[alu_pkg::STAT_C]    = arith_overflow_bit;
			next_prdata[alu_pkg::STAT_DC]   = half_carry_flag;
			next_prdata[alu_pkg::STAT_Z]    = result_null_flag;
			next_prdata[alu_pkg::STAT_SKIP] = skip_active;
			next_prdata[alu_pkg::STAT_BAD]  = bad_op;
		end else if (hit_file) begin
			next_prdata[7:0] = bus_file_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= next_prdata;
		end else if (!psel) begin
			prdata <= 32'h0000_0000;
		end
	end

endmodule : acc_core
`default_nettype wire

// ==== logic/alu_pkg.sv ====
`default_nettype none
package alu_pkg;

	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned FILE_AW = 7;
	localparam int unsigned FILE_N  = 128;

	localparam logic [11:0] CMD_OFFSET    = 12'h000;
	localparam logic [11:0] ACC_OFFSET    = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;
	localparam logic [2:0]  FILE_PAGE     = 3'h1;

	localparam int unsigned IMM_LSB   = 0;
	localparam int unsigned FADDR_LSB = 8;
	localparam int unsigned BIT_LSB   = 16;
	localparam int unsigned DEST_POS  = 20;
	localparam int unsigned OP_LSB    = 24;

	localparam int unsigned STAT_C    = 0;
	localparam int unsigned STAT_DC   = 1;
	localparam int unsigned STAT_Z    = 2;
	localparam int unsigned STAT_SKIP = 3;
	localparam int unsigned STAT_BAD  = 4;

	localparam logic [7:0] ACC_RESET  = 8'h00;
	localparam logic       FLAG_RESET = 1'b0;

	typedef enum logic [3:0] {
		OP_IDLE      = 4'h0,
		OP_ADD_IMM   = 4'h1,
		OP_ADD_REG   = 4'h2,
		OP_AND_IMM   = 4'h3,
		OP_AND_REG   = 4'h4,
		OP_BIT_CLEAR = 4'h5,
		OP_BIT_SET   = 4'h6,
		OP_SKIP_ZERO = 4'h7,
		OP_MOVE_REG  = 4'h8,
		OP_STORE_ACC = 4'h9,
		OP_LOAD_IMM  = 4'hA
	} op_t;

	typedef struct packed {
		op_t        op;
		logic       dest;
		logic [2:0] bitpos;
		logic [6:0] faddr;
		logic [7:0] imm;
	} instr_t;

	typedef struct packed {
		logic [7:0] result;
		logic       carry;
		logic       half;
		logic       zero;
		logic       wr_acc;
		logic       wr_file;
		logic       upd_c;
		logic       upd_dc;
		logic       upd_z;
		logic       skip;
		logic       bad;
	} alu_out_t;

	typedef enum logic [1:0] {
		EXEC_RUN  = 2'b01,
		EXEC_SKIP = 2'b10
	} exec_state_t;

endpackage : alu_pkg
`default_nettype wire

// ==== logic/op_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module op_unit (
	input  wire logic              [7:0] acc,
	input  wire logic              [7:0] file_val,
	input  wire alu_pkg::instr_t         instr,
	output alu_pkg::alu_out_t            out
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] opnd;
	logic [7:0] mask;

	always_comb begin
		opnd    = (instr.op == alu_pkg::OP_ADD_IMM) ? instr.imm : file_val;
		sum     = {1'b0, acc} + {1'b0, opnd};
		low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
		mask    = 8'h01 << instr.bitpos;
	end

	always_comb begin
		out         = '0;
		out.carry   = sum[8];
		out.half    = low_sum[4];
		unique case (instr.op)
			alu_pkg::OP_IDLE: begin
				out.result = acc;
			end
			alu_pkg::OP_ADD_IMM: begin
				out.result = sum[7:0];
				out.wr_acc = 1'b1;
				out.upd_c  = 1'b1;
				out.upd_dc = 1'b1;
				out.upd_z  = 1'b1;
			end
			alu_pkg::OP_ADD_REG: begin
				out.result  = sum[7:0];
				out.wr_acc  = ~instr.dest;
				out.wr_file = instr.dest;
				out.upd_c   = 1'b1;
				out.upd_dc  = 1'b1;
				out.upd_z   = 1'b1;
			end
			alu_pkg::OP_AND_IMM: begin
				out.result = acc & instr.imm;
				out.wr_acc = 1'b1;
				out.upd_z  = 1'b1;
			end
			alu_pkg::OP_AND_REG: begin
				out.result  = acc & file_val;
				out.wr_acc  = ~instr.dest;
				out.wr_file = instr.dest;
				out.upd_z   = 1'b1;
			end
			alu_pkg::OP_BIT_CLEAR: begin
				out.result  = file_val & ~mask;
				out.wr_file = 1'b1;
			end
			alu_pkg::OP_BIT_SET: begin
				out.result  = file_val | mask;
				out.wr_file = 1'b1;
			end
			alu_pkg::OP_SKIP_ZERO: begin
				out.result = file_val;
				out.skip   = ~file_val[instr.bitpos];
			end
			alu_pkg::OP_MOVE_REG: begin
				out.result  = file_val;
				out.wr_acc  = ~instr.dest;
				out.wr_file = instr.dest;
				out.upd_z   = 1'b1;
			end
			alu_pkg::OP_STORE_ACC: begin
				out.result  = acc;
				out.wr_file = 1'b1;
			end
			alu_pkg::OP_LOAD_IMM: begin
				out.result = instr.imm;
				out.wr_acc = 1'b1;
			end
			default: begin
				out.result = acc;
				out.bad    = 1'b1;
			end
		endcase
		out.zero = (out.result == 8'h00);
	end
endmodule : op_unit
`default_nettype wire

// ==== logic/file_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module file_ram (
	input  wire logic       pclk,
	input  wire logic       wr_en,
	input  wire logic [6:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [6:0] exec_addr,
	output logic      [7:0] exec_data,
	input  wire logic [6:0] bus_addr,
	output logic      [7:0] bus_data
);
	// Contents are not reset, as with a real data memory
	logic [7:0] mem [alu_pkg::FILE_N];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign exec_data = mem[exec_addr];
	assign bus_data  = mem[bus_addr];
endmodule : file_ram
`default_nettype wire

// ==== test/acc_core_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module acc_core_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  accumulator,
	input wire logic        arith_overflow_bit,
	input wire logic        half_carry_flag,
	input wire logic        result_null_flag,
	input wire logic        skip_active,
	input wire logic        exec_done
);
	logic       cmd_any;
	logic       ex;
	logic [3:0] op;
	logic [2:0] flags;
	logic [7:0] acc_q;
	logic [7:0] imm_q;
	assign cmd_any = psel && penable && pready && pwrite && paddr == alu_pkg::CMD_OFFSET;
	assign ex = cmd_any && !skip_active;
	assign op = pwdata[27:24];
	assign flags = {result_null_flag, half_carry_flag, arith_overflow_bit};
	// Operands as they stood at the committing edge
	always_ff @(posedge pclk) begin
		acc_q <= accumulator;
		imm_q <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY: assert property (psel && !penable |=> pready) else $error("no zero-wait answer");
	AST_DONE: assert property (cmd_any |=> exec_done) else $error("no completion pulse");
	AST_ADD_IMM: assert property (ex && op == 4'h1 |=>
		{arith_overflow_bit, accumulator} == {1'b0, acc_q} + {1'b0, imm_q}
		&& half_carry_flag == (({1'b0, acc_q[3:0]} + {1'b0, imm_q[3:0]}) > 5'h0F)
		&& result_null_flag == (accumulator == 8'h00)) else $error("bad add result");
	AST_AND_IMM: assert property (ex && op == 4'h3 |=> accumulator == (acc_q & imm_q)
		&& $stable(arith_overflow_bit) && $stable(half_carry_flag)) else $error("bad and result");
	AST_LOAD: assert property (ex && op == 4'hA |=> accumulator == imm_q && $stable(flags))
		else $error("bad load");
	AST_QUIET: assert property (ex && op inside {4'h5, 4'h6, 4'h7, 4'h9}
		|=> $stable({flags, accumulator})) else $error("bit or store op moved state");
	AST_IDLE: assert property (ex && op == 4'h0 |=> $stable({flags, accumulator}))
		else $error("idle moved state");
	AST_SKIP: assert property (cmd_any && skip_active |=> !skip_active && $stable(accumulator))
		else $error("discarded command ran");
	AST_ZFLAG: assert property (ex && op inside {4'h4, 4'h8} && !pwdata[20]
		|=> result_null_flag == (accumulator == 8'h00) && $stable(arith_overflow_bit) && $stable(half_carry_flag))
		else $error("bad zero flag");
endmodule : acc_core_sva
bind acc_core acc_core_sva acc_core_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.accumulator(accumulator), .arith_overflow_bit(arith_overflow_bit), .half_carry_flag(half_carry_flag),
	.result_null_flag(result_null_flag), .skip_active(skip_active), .exec_done(exec_done));
`default_nettype wire

// ==== test/apb_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module apb_sequencer (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'hFFF;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Scrambled when idle so stale values never pass as valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_sequencer
`default_nettype wire

// ==== test/acc_core_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module acc_core_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  accumulator, x;
	logic        arith_overflow_bit, half_carry_flag, result_null_flag, skip_active, exec_done;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	always #25 pclk = ~pclk;
	acc_core acc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.accumulator(accumulator), .arith_overflow_bit(arith_overflow_bit), .half_carry_flag(half_carry_flag),
		.result_null_flag(result_null_flag), .skip_active(skip_active), .exec_done(exec_done));
	apb_sequencer apb_sequencer_inst (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	////////////////////////////////////////
	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	function automatic logic [11:0] fa(input logic [6:0] n);
		return 12'h200 + {3'h0, n, 2'b00};
	endfunction : fa
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb_sequencer_inst.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		apb_sequencer_inst.xfer(1'b0, a, 32'h0, q, e);
		chk("register", ex, q);
	endtask : rd
	task automatic cmd(input logic [3:0] op, input logic [6:0] f, input logic [2:0] b, input logic d,
		input logic [7:0] k);
		wr(alu_pkg::CMD_OFFSET, {4'h0, op, 3'h0, d, 1'b0, b, 1'b0, f, k});
		@(negedge pclk);
		chk("exec done", 32'h1, {31'h0, exec_done});
	endtask : cmd
	// Flags as {zero, half carry, carry}
	task automatic see(input logic [7:0] a, input logic [2:0] f);
		@(negedge pclk);
		chk("accumulator", {24'h0, a}, {24'h0, accumulator});
		chk("flags", {29'h0, f}, {29'h0, result_null_flag, half_carry_flag, arith_overflow_bit});
		chk("exec done idle", 32'h0, {31'h0, exec_done});
	endtask : see
	////////////////////////////////////////
	task automatic t_arith;
		see(8'h00, 3'b000);
		cmd(4'hA, 0, 0, 0, 8'h8F); see(8'h8F, 3'b000);
		cmd(4'h1, 0, 0, 0, 8'h71); see(8'h00, 3'b111);
		cmd(4'hA, 0, 0, 0, 8'hFF); see(8'hFF, 3'b111);
		cmd(4'h3, 0, 0, 0, 8'h0F); see(8'h0F, 3'b011);
		cmd(4'h1, 0, 0, 0, 8'h01); see(8'h10, 3'b010);
		cmd(4'h0, 0, 0, 0, 8'h55); see(8'h10, 3'b010);
		$display("t_arith done");
	endtask : t_arith
	task automatic t_reg;
		wr(fa(5), 32'hF8);
		cmd(4'h2, 5, 0, 1, 0); see(8'h10, 3'b001);
		rd(fa(5), 32'h08);
		cmd(4'h2, 5, 0, 0, 0); see(8'h18, 3'b000);
		wr(fa(6), 32'hE7);
		cmd(4'h4, 6, 0, 1, 0); see(8'h18, 3'b100);
		rd(fa(6), 32'h00);
		cmd(4'h4, 5, 0, 0, 0); see(8'h08, 3'b000);
		$display("t_reg done");
	endtask : t_reg
	task automatic t_bits;
		x = 8'h00;
		wr(fa(7), 32'h0);
		for (int b = 0; b < 8; b++) begin
			cmd(4'h6, 7, 3'(b), 0, 0);
			x[b] = 1'b1;
			rd(fa(7), {24'h0, x});
		end
		cmd(4'h5, 7, 7, 0, 0); rd(fa(7), 32'h7F);
		cmd(4'h5, 7, 0, 0, 0); rd(fa(7), 32'h7E);
		see(8'h08, 3'b000);
		$display("t_bits done");
	endtask : t_bits
	task automatic t_skip;
		wr(fa(8), 32'h01);
		cmd(4'h7, 8, 0, 0, 0);
		cmd(4'hA, 0, 0, 0, 8'h11); see(8'h11, 3'b000);
		cmd(4'h7, 8, 1, 0, 0);
		rd(alu_pkg::STATUS_OFFSET, 32'h08);
		cmd(4'hA, 0, 0, 0, 8'h22); see(8'h11, 3'b000);
		cmd(4'hA, 0, 0, 0, 8'h33); see(8'h33, 3'b000);
		$display("t_skip done");
	endtask : t_skip
	task automatic t_move;
		cmd(4'h9, 9, 0, 0, 0); rd(fa(9), 32'h33);
		cmd(4'hA, 0, 0, 0, 8'h00);
		cmd(4'h8, 9, 0, 0, 0); see(8'h33, 3'b000);
		wr(fa(10), 32'h0);
		cmd(4'h8, 10, 0, 1, 0); see(8'h33, 3'b100);
		rd(fa(10), 32'h00);
		apb_sequencer_inst.xfer(1'b0, 12'h100, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		$display("t_move done");
	endtask : t_move
	task automatic t_regs;
		wr(alu_pkg::ACC_OFFSET, 32'hA5);
		rd(alu_pkg::ACC_OFFSET, 32'hA5);
		wr(alu_pkg::STATUS_OFFSET, 32'h07);
		see(8'hA5, 3'b111);
		// Undefined opcode behaves as idle and raises the sticky mark
		cmd(4'hB, 0, 0, 0, 8'h00); see(8'hA5, 3'b111);
		rd(alu_pkg::STATUS_OFFSET, 32'h17);
		wr(alu_pkg::STATUS_OFFSET, 32'h10);
		rd(alu_pkg::STATUS_OFFSET, 32'h00);
		rd(alu_pkg::CMD_OFFSET, 32'h00);
		apb_sequencer_inst.xfer(1'b0, 12'h006, 32'h0, q, e);
		chk("misaligned error", 32'h1, {31'h0, e});
		chk("misaligned data", 32'h0, q);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_reset;
		cmd(4'hA, 0, 0, 0, 8'h5A);
		cmd(4'h7, 8, 1, 0, 0);
		chk("skip armed", 32'h1, {31'h0, skip_active});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		see(8'h00, 3'b000);
		chk("skip after reset", 32'h0, {31'h0, skip_active});
		cmd(4'hA, 0, 0, 0, 8'h66); see(8'h66, 3'b000);
		$display("t_reset done");
	endtask : t_reset
	////////////////////////////////////////
	// Whole run is a few hundred cycles; the ceiling only catches a hang
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_arith();
		t_reg();
		t_bits();
		t_skip();
		t_move();
		t_regs();
		t_reset();
		close_out();
	end
endmodule : acc_core_test
`default_nettype wire
